//--- rtl/adc_seq_map.svh
// Register offsets, field positions, reset values and cycle counts
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL0 12'h000
`define OFS_CTRL1 12'h004
`define OFS_CTRL2 12'h008
`define OFS_STATUS 12'h00C
`define OFS_RESULT 12'h020
`define RESULT_CNT 8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define F0_CHAN 2:0
`define F0_MODE 5:3
`define F0_TRIGSEL 6
`define F0_START 7
`define F1_REFCON 0
`define F1_RES10 1
`define F1_SHEN 2
`define F1_DIV 5:3
`define F2_TSRC 1:0
`define F2_PGRP 3:2
`define F2_DMA 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CTRL0 8'h00
`define RST_CTRL1 6'h00
`define RST_CTRL2 5'h00

// ----------------------------------------
// Divider ratios and cycles per conversion
// ----------------------------------------
`define DIV_R0 4'h1
`define DIV_R1 4'h2
`define DIV_R2 4'h3
`define DIV_R3 4'h4
`define DIV_R4 4'h6
`define DIV_R5 4'h8
`define CYC_8_NOSH 6'd49
`define CYC_10_NOSH 6'd59
`define CYC_8_SH 6'd28
`define CYC_10_SH 6'd33
`define BITS_8 6'd8
`define BITS_10 6'd10
`define SAR_MSB 10'h200

`endif

//--- rtl/adc_seq_pkg.sv
// Types shared by the converter sequencer modules
package adc_seq_pkg;

	typedef enum logic [2:0] {
		MODE_ONESHOT = 3'h0,
		MODE_REPEAT = 3'h1,
		MODE_SWEEP = 3'h2,
		MODE_RSWEEP0 = 3'h3,
		MODE_RSWEEP1 = 3'h4,
		MODE_SELFTEST = 3'h5
	} mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SAMPLE = 2'h1,
		ST_CONVERT = 2'h3
	} conv_state_t;

	typedef enum logic [1:0] {
		TSRC_EXT = 2'h0,
		TSRC_TB2 = 2'h1,
		TSRC_TA0 = 2'h2
	} tsrc_t;

	typedef struct packed {
		logic [2:0] chan_sel;
		mode_t mode;
		logic trig_sel;
		logic start;
		logic ref_conn;
		logic res10;
		logic sh_en;
		logic [2:0] div_sel;
		logic [1:0] trig_src;
		logic [1:0] port_grp;
		logic dma;
		conv_state_t state;
		logic [5:0] cnt;
		logic [2:0] ch;
		logic [9:0] trial;
		logic [7:0][9:0] result;
		logic [31:0] rdata;
		logic irq;
	} seq_state_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic tick;
	} div_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic fall;
	} sync_state_t;

endpackage

//--- rtl/conv_clk_div.sv
// Conversion clock enable divider
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"
module conv_clk_div import adc_seq_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic clr,
	input wire logic [2:0] div_sel,
	output logic tick
);
	div_state_t q, d;
	logic [3:0] ratio;

	always_comb begin
		case (div_sel)
			3'h0: ratio = `DIV_R0;
			3'h1: ratio = `DIV_R1;
			3'h2: ratio = `DIV_R2;
			3'h3: ratio = `DIV_R3;
			3'h4: ratio = `DIV_R4;
			3'h5: ratio = `DIV_R5;
			default: ratio = `DIV_R5;
		endcase
	end

	// Tick once every ratio clocks
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (clr) begin
			d.cnt = 4'h0;
		end else if (q.cnt >= ratio - 4'h1) begin
			d.cnt = 4'h0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign tick = q.tick;
endmodule
`default_nettype wire

//--- rtl/ext_trig_sync.sv
// External trigger synchroniser and falling-edge detector
`timescale 1ns/1ps
`default_nettype none
module ext_trig_sync import adc_seq_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic pin,
	output logic fall
);
	sync_state_t q, d;

	// Two flops, then edge from settled samples
	always_comb begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.fall = q.s3 & ~q.s2;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= 4'hE;
		end else if (ce) begin
			q <= d;
		end
	end

	assign fall = q.fall;
endmodule
`default_nettype wire

//--- rtl/adc_trigger_sequencer.sv
// Converter sequencer: APB registers, triggers, SAR control, results
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"
module adc_trigger_sequencer import adc_seq_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_trigger_pin,
	input wire logic tmr_a0_req,
	input wire logic tmr_b2_thin_req,
	input wire logic cmp_in,
	output logic [9:0] sar_trial,
	output logic sample_on,
	output logic [4:0] ana_chan,
	output logic self_test_on,
	output logic ref_connect_bit,
	output logic conv_busy,
	output logic conv_irq
);
	seq_state_t q, n;
	logic conv_tick;
	logic ext_fall;
	logic wr_en;
	logic map_ok;
	logic [31:0] rd_val;
	logic trig_evt;
	logic [5:0] tot;
	logic [5:0] bits;
	logic [5:0] samp_n;
	logic [5:0] k;
	logic [3:0] p;
	logic [9:0] t;
	logic [9:0] resv;
	logic [2:0] ridx;
	logic sweep;
	logic launch;
	logic [2:0] widx;

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	conv_clk_div u_div (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.clr(q.state == ST_IDLE),
		.div_sel(q.div_sel),
		.tick(conv_tick)
	);

	ext_trig_sync u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.pin(ext_trigger_pin),
		.fall(ext_fall)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign wr_en = psel & penable & pwrite;
	assign widx = paddr[4:2];

	always_comb begin
		map_ok = 1'b1;
		rd_val = 32'h0;
		case (paddr)
			`OFS_CTRL0: rd_val = {24'h0, q.start, q.trig_sel, q.mode,
				q.chan_sel};
			`OFS_CTRL1: rd_val = {26'h0, q.div_sel, q.sh_en, q.res10,
				q.ref_conn};
			`OFS_CTRL2: rd_val = {27'h0, q.dma, q.port_grp, q.trig_src};
			`OFS_STATUS: rd_val = {28'h0, q.ch, q.state != ST_IDLE};
			default: begin
				if (paddr[11:5] == `OFS_RESULT >> 5 && paddr[1:0] == 2'h0) begin
					rd_val = {22'h0, q.result[widx]};
				end else begin
					map_ok = 1'b0;
				end
			end
		endcase
	end

	// ----------------------------------------
	// Cycle budget
	// ----------------------------------------
	always_comb begin
		case ({q.sh_en, q.res10})
			2'b00: tot = `CYC_8_NOSH;
			2'b01: tot = `CYC_10_NOSH;
			2'b10: tot = `CYC_8_SH;
			2'b11: tot = `CYC_10_SH;
			default: tot = `CYC_10_NOSH;
		endcase
		bits = q.res10 ? `BITS_10 : `BITS_8;
		samp_n = tot - bits;
	end

	// ----------------------------------------
	// Trigger selection
	// ----------------------------------------
	always_comb begin
		case (tsrc_t'(q.trig_src))
			TSRC_EXT: trig_evt = ext_fall;
			TSRC_TB2: trig_evt = tmr_b2_thin_req;
			TSRC_TA0: trig_evt = tmr_a0_req;
			default: trig_evt = 1'b0;
		endcase
	end

	assign sweep = q.mode == MODE_SWEEP || q.mode == MODE_RSWEEP0 ||
		q.mode == MODE_RSWEEP1;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = q;
		n.irq = 1'b0;
		launch = 1'b0;
		k = q.cnt - samp_n;
		p = 4'h9 - k[3:0];
		t = q.trial;
		resv = 10'h0;
		ridx = q.dma ? 3'h0 : q.ch;
		if (psel && !penable) begin
			n.rdata = rd_val;
		end
		// Successive approximation steps
		if (conv_tick && q.state == ST_SAMPLE) begin
			n.cnt = q.cnt + 6'h1;
			if (q.cnt == samp_n - 6'h1) begin
				n.trial = `SAR_MSB;
				n.state = ST_CONVERT;
			end
		end else if (conv_tick && q.state == ST_CONVERT) begin
			if (!cmp_in) begin
				t[p] = 1'b0;
			end
			if (q.cnt == tot - 6'h1) begin
				resv = q.res10 ? t : {2'b00, t[9:2]};
				n.result[ridx] = resv;
				n.trial = t;
				n.cnt = 6'h0;
				n.state = ST_SAMPLE;
				if (sweep) begin
					if (q.ch == q.chan_sel) begin
						n.ch = 3'h0;
						if (q.mode == MODE_SWEEP) begin
							n.state = ST_IDLE;
							n.irq = 1'b1;
							n.start = q.trig_sel;
						end
					end else begin
						n.ch = q.ch + 3'h1;
					end
				end else if (q.mode == MODE_REPEAT) begin
					n.irq = q.dma;
				end else begin
					n.state = ST_IDLE;
					n.irq = 1'b1;
					if (!q.trig_sel) begin
						n.start = 1'b0;
					end
				end
			end else begin
				t[p - 4'h1] = 1'b1;
				n.trial = t;
				n.cnt = q.cnt + 6'h1;
			end
		end
		// Armed external or hardware trigger restarts
		if (q.start && q.trig_sel && trig_evt) begin
			launch = 1'b1;
		end
		// Register writes land last so a write wins over a same-cycle sequencer update
		if (wr_en) begin
			case (paddr)
				`OFS_CTRL0: begin
					n.chan_sel = pwdata[`F0_CHAN];
					n.mode = mode_t'(pwdata[`F0_MODE]);
					n.trig_sel = pwdata[`F0_TRIGSEL];
					n.start = pwdata[`F0_START];
					if (pwdata[`F0_START] && !pwdata[`F0_TRIGSEL]) begin
						launch = 1'b1;
					end
					if (!pwdata[`F0_START]) begin
						n.state = ST_IDLE;
						launch = 1'b0;
					end
				end
				`OFS_CTRL1: begin
					n.ref_conn = pwdata[`F1_REFCON];
					n.res10 = pwdata[`F1_RES10];
					n.sh_en = pwdata[`F1_SHEN];
					n.div_sel = pwdata[`F1_DIV];
				end
				`OFS_CTRL2: begin
					n.trig_src = pwdata[`F2_TSRC];
					n.port_grp = pwdata[`F2_PGRP];
					n.dma = pwdata[`F2_DMA];
				end
				default: begin
				end
			endcase
		end
		// Restart mid-conversion discards partial result
		if (launch) begin
			n.state = ST_SAMPLE;
			n.cnt = 6'h0;
			n.trial = 10'h0;
			n.ch = (n.mode == MODE_SWEEP || n.mode == MODE_RSWEEP0 ||
				n.mode == MODE_RSWEEP1) ? 3'h0 : n.chan_sel;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
		end else if (ce) begin
			q <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = q.rdata;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~map_ok;
	assign sar_trial = q.trial;
	assign sample_on = q.state == ST_SAMPLE;
	assign ana_chan = {q.port_grp, q.ch};
	assign self_test_on = q.mode == MODE_SELFTEST;
	assign ref_connect_bit = q.ref_conn;
	assign conv_busy = q.state != ST_IDLE;
	assign conv_irq = q.irq;
endmodule
`default_nettype wire

//--- sim/adc_seq_monitor.sv
// Assertions on the converter sequencer ports
`timescale 1ns/1ps
`default_nettype none
module adc_seq_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic conv_busy,
	input wire logic conv_irq,
	input wire logic ref_connect_bit,
	input wire logic self_test_on
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic acc, wr, map;
	assign acc = psel && penable;
	assign wr = acc && pwrite && ce;
	assign map = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}
		|| (paddr[11:5] == 7'h01 && paddr[1:0] == 2'h0);
	sequence s_go;
		wr && paddr == 12'h000 && pwdata[7] && !pwdata[6];
	endsequence
	sequence s_stop;
		wr && paddr == 12'h000 && !pwdata[7];
	endsequence
	a_ready_now: assert property (pready == acc) else $error("pready");
	a_err_unmap: assert property (acc |-> pslverr == !map) else $error("slverr");
	a_sw_go: assert property (s_go |=> conv_busy)
		else $error("no start");
	a_halt_now: assert property (s_stop |=> !conv_busy)
		else $error("no halt");
	a_conv_min: assert property ($rose(conv_busy) |-> conv_busy[*8])
		else $error("short");
	a_conv_max: assert property ($rose(conv_busy) |-> ##[1:600] !conv_busy)
		else $error("long");
	a_irq_pulse: assert property (conv_irq |=> !conv_irq)
		else $error("irq width");
	a_irq_end: assert property (conv_irq |-> !conv_busy && $past(conv_busy))
		else $error("irq time");
	a_ref_set: assert property (wr && paddr == 12'h004 |=>
		ref_connect_bit == $past(pwdata[0])) else $error("ref");
	a_ref_hold: assert property (!(wr && paddr == 12'h004) |=>
		$stable(ref_connect_bit)) else $error("ref moved");
	a_mode_test: assert property (wr && paddr == 12'h000 |=>
		self_test_on == ($past(pwdata[5:3]) == 3'h5)) else $error("mode");
endmodule
bind adc_trigger_sequencer adc_seq_monitor u_adc_seq_monitor (.clk, .sys_rst,
	.ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.conv_busy, .conv_irq, .ref_connect_bit, .self_test_on);
`default_nettype wire

//--- sim/far_side_model.sv
// Analog inputs and trigger sources facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
	input wire logic clk,
	input wire logic [9:0] sar_trial,
	input wire logic [4:0] ana_chan,
	output logic cmp_in,
	output logic ext_trigger_pin = 1'b1,
	output logic tmr_a0_req = 1'b0,
	output logic tmr_b2_thin_req = 1'b0
);
	logic [9:0] vin;
	// Level per implemented channel
	assign vin = {ana_chan, 5'h00} ^ 10'h2B5;
	assign cmp_in = vin >= sar_trial;
	// Source 0 pin fall, 1 thinned B2, 2 timer A0
	task automatic fire(input int k);
		@(posedge clk);
		ext_trigger_pin <= (k != 0);
		tmr_b2_thin_req <= (k == 1);
		tmr_a0_req <= (k == 2);
		@(posedge clk);
		tmr_b2_thin_req <= 1'b0;
		tmr_a0_req <= 1'b0;
		repeat (3) @(posedge clk);
		ext_trigger_pin <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, sys_rst, ce, psel, penable, pwrite, pready, pslverr, cmp_in;
	logic ext_trigger_pin, tmr_a0_req, tmr_b2_thin_req, sample_on, err;
	logic self_test_on, ref_connect_bit, conv_busy, conv_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0] sar_trial;
	logic [4:0] ana_chan;
	int n_fail = 0, num_checks = 0, cyc = 0, n, q;
	int r[6] = '{1, 2, 3, 4, 6, 8};
	int t4[4] = '{49, 59, 28, 33};
	adc_trigger_sequencer u_adc_trigger_sequencer (.clk, .sys_rst, .ce,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ext_trigger_pin, .tmr_a0_req, .tmr_b2_thin_req, .cmp_in, .sar_trial,
		.sample_on, .ana_chan, .self_test_on, .ref_connect_bit, .conv_busy,
		.conv_irq);
	far_side_model u_far_side_model (.clk, .sar_trial, .ana_chan, .cmp_in,
		.ext_trigger_pin, .tmr_a0_req, .tmr_b2_thin_req);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	task automatic run(output int b, output int p);
		b = 0;
		p = 0;
		do begin
			@(negedge clk);
			b++;
			p += (conv_irq === 1'b1);
		end while (conv_busy === 1'b1 && b < 2000);
	endtask
	task automatic conv(input logic [5:0] c1, input int t, d, input logic [9:0] e);
		int b, p;
		apb(1'b1, 12'h004, {26'h0, c1});
		apb(1'b1, 12'h000, 32'h83);
		@(negedge clk);
		chk("samp", sample_on, 1'b1);
		run(b, p);
		chk("trial", sar_trial, c1[1] ? e : {e[7:0], 2'b00});
		chk("len", b - 1 >= t * d - d && b - 1 <= t * d + 1, 1'b1);
		chk("irq", p, 1);
		rchk("start", 12'h000, 32'h03);
		rchk("res", 12'h02C, e);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		sys_rst = 1'b1;
		ce = 1'b1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rchk("ctrl0", 12'h000, 0);
		rchk("ctrl1", 12'h004, 0);
		rchk("ctrl2", 12'h008, 0);
		rchk("bad", 12'h010, 0);
		chk("err", err, 1'b1);
		apb(1'b1, 12'h004, 32'h1);
		@(negedge clk);
		chk("ref", ref_connect_bit, 1'b1);
		for (int m = 0; m < 6; m++) begin
			apb(1'b1, 12'h000, m << 3);
			@(negedge clk);
			chk("test", self_test_on, m == 5);
			rchk("mode", 12'h000, m << 3);
		end
		for (int i = 0; i < 4; i++) begin
			conv({3'h0, i[1:0], 1'b1}, t4[i], 1, i[0] ? 10'h2D5 : 10'h0B5);
		end
		for (int k = 1; k < 6; k++) begin
			conv({k[2:0], 3'h5}, 28, r[k], 10'h0B5);
		end
		apb(1'b1, 12'h004, 32'h7);
		apb(1'b1, 12'h008, 32'h18);
		apb(1'b1, 12'h000, 32'h86);
		@(negedge clk);
		chk("chan", ana_chan, 5'h16);
		run(n, q);
		rchk("dma", 12'h020, 32'h075);
		rchk("res6", 12'h038, 0);
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b1, 12'h000, 32'h91);
		run(n, q);
		chk("swirq", q, 1);
		rchk("sw0", 12'h020, 32'h2B5);
		rchk("sw1", 12'h024, 32'h295);
		rchk("swst", 12'h000, 32'h11);
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, 12'h008, k);
			apb(1'b1, 12'h000, 32'h41);
			apb(1'b1, 12'h000, 32'hC1);
			u_far_side_model.fire((k + 1) % 3);
			u_far_side_model.fire((k + 2) % 3);
			repeat (4) @(negedge clk);
			chk("idle", conv_busy, 1'b0);
			for (int j = 0; j < 3; j++) begin
				u_far_side_model.fire(k);
				n = 0;
				do begin
					@(negedge clk);
					n++;
				end while (conv_busy !== 1'b1 && n < 12);
				chk("trig", conv_busy, 1'b1);
				if (j < 2) begin
					run(n, q);
					rchk("armed", 12'h000, 32'hC1);
				end
			end
			repeat (12) @(negedge clk);
			apb(1'b1, 12'h000, 32'h41);
			@(negedge clk);
			chk("halt", conv_busy, 1'b0);
		end
		stop_test();
	end
endmodule
`default_nettype wire
